//--- rtl/veqlc_pkg.sv
// Package: constants and carrier types for the video equalizer lock control
package veqlc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned CLK_PER_US       = 40;
  localparam int unsigned TOGGLE_MIN_US    = 1000;                          // 1 ms polarity pulse
  localparam int unsigned TOGGLE_MIN_CYC   = TOGGLE_MIN_US * CLK_PER_US;     // Least time, exact
  localparam int unsigned EQ_SWITCH_NS     = 500;                           // Longest on/off time
  localparam int unsigned EQ_SWITCH_CYC    = EQ_SWITCH_NS / CLK_PERIOD_NS;  // Rounded down
  localparam int unsigned TOGGLE_CNT_W     = 17;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  OFF_CTRL         = 8'h00;
  localparam logic [7:0]  OFF_STATUS       = 8'h04;
  localparam logic [7:0]  OFF_SETTLE       = 8'h08;

  // Field positions
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned ST_LOCK_BIT      = 0;
  localparam int unsigned ST_FREEZE_BIT    = 1;
  localparam int unsigned ST_INVERT_BIT    = 2;
  localparam int unsigned ST_COLOR_BIT     = 3;
  localparam int unsigned ST_SIGNAL_BIT    = 4;
  localparam int unsigned ST_EQ_EN_BIT     = 5;
  localparam int unsigned ST_STATE_LSB     = 8;
  localparam int unsigned ST_RSTCNT_LSB    = 16;

  // Settle threshold width and reset value
  localparam int unsigned SETTLE_W         = 8;
  localparam logic [7:0]  SETTLE_LINES_RST = 8'h64;                         // 100 video lines

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    VEQLC_ACQ  = 3'b001,
    VEQLC_LOCK = 3'b010,
    VEQLC_HOLD = 3'b100
  } veqlc_state_t;

  typedef struct packed {
    logic              sel;
    logic              en;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } veqlc_apb_req_t;

  typedef struct packed {
    logic [7:0]   restarts;
    veqlc_state_t state;
    logic         eq_en;
    logic         signal;
    logic         color;
    logic         invert;
    logic         freeze;
    logic         lock;
  } veqlc_status_t;

endpackage : veqlc_pkg

//--- rtl/veqlc_settle_cnt.sv
// Counter of consecutive video lines without an equalizer setting change
`timescale 1ns/1ps
module veqlc_settle_cnt #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         clear,
  input  wire logic         line,
  input  wire logic         change,
  input  wire logic [W-1:0] thresh,
  output logic              done
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // ----------------------------------------------------------------
  // Count lines, restart on any change
  // ----------------------------------------------------------------
  assign done      = (count_r >= thresh);
  assign count_nxt = (clear || change) ? '0 :
                     (line && !done)   ? count_r + 1'b1 : count_r;

  // Line counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (clk_en) begin
      count_r <= count_nxt;
    end
  end

endmodule : veqlc_settle_cnt

//--- rtl/veqlc_toggle_qual.sv
// Qualifier for an external pulse held against the driven pin level
`timescale 1ns/1ps
module veqlc_toggle_qual #(
  parameter int unsigned W       = 17,
  parameter int unsigned MIN_CYC = 40000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic mismatch,
  output logic      fire
);

  localparam logic [W-1:0] MIN_V = W'(MIN_CYC);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         long_enough;

  // ----------------------------------------------------------------
  // Saturating width measurement, fire on release
  // ----------------------------------------------------------------
  assign long_enough = (cnt_r >= MIN_V);
  assign fire        = !mismatch && long_enough;
  assign cnt_nxt     = !mismatch   ? '0 :
                       long_enough ? cnt_r : cnt_r + 1'b1;

  // Width counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : veqlc_toggle_qual

//--- rtl/veqlc_top.sv
// Mode and lock control around an adaptive cable video equalizer, APB slave
//
// Notes on behaviour
// (RQ1) Freeze-on-lock: settings held once lock_indicator until power cycle or polarity reset.
// (RQ2) Polarity line forced opposite at least 1 ms then restored restarts equalization.
// (RQ3) Freeze-on-lock keeps lock high through signal loss, until a polarity reset.
// (RQ4) Board ties lock output to hold-select to choose freeze-on-lock operation.
// (RQ5) Continuous mode: lock rises after 100 consecutive unchanged video lines.
// (RQ6) Continuous mode: disturbance after lock drops lock and resumes equalizing.
// (RQ7) Hold-select low always means continuous adaptation.
// (RQ8) Drive polarity line high when inputs swapped, low when nominal; invert path.
// (RQ9) Externally forced polarity level decides inversion, not the detector.
// (RQ10) Drive chroma line high for colorburst, low for monochrome; processing uses it.
// (RQ11) Externally forced chroma level replaces the burst detector result.
// (RQ12) After reset the block acquires and equalizes with no command.
// (RQ13) Equalization on or off within 500 ns of the disable control; eq_enable follows it one cycle later, and only on clk_en cycles.
// (RQ14) A restart drops lock and keeps it low until equalization settles again.
`timescale 1ns/1ps
module veqlc_top #(
  parameter int unsigned TOGGLE_MIN_CYC = veqlc_pkg::TOGGLE_MIN_CYC,
  parameter int unsigned SETTLE_W       = veqlc_pkg::SETTLE_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Equalizer engine side
  input  wire logic        line_strobe,
  input  wire logic        eq_settings_changed,
  input  wire logic        signal_present,
  input  wire logic        polarity_detect,
  input  wire logic        burst_detect,
  output logic             eq_freeze,
  output logic             eq_restart,
  output logic             eq_enable,
  output logic             path_invert,
  output logic             path_color,
  // Control pins
  input  wire logic        hold_select,
  input  wire logic        equalization_off,
  output logic             lock_indicator,
  input  wire logic        polarity_pin_in,
  output logic             polarity_pin_out,
  output logic             polarity_pin_oe_n,
  input  wire logic        chroma_pin_in,
  output logic             chroma_pin_out,
  output logic             chroma_pin_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  veqlc_pkg::veqlc_apb_req_t req;
  veqlc_pkg::veqlc_status_t  status;
  veqlc_pkg::veqlc_state_t   state_r;
  veqlc_pkg::veqlc_state_t   state_nxt;

  logic [31:0]         prdata_r;
  logic [31:0]         prdata_nxt;
  logic                pready_r;
  logic                pslverr_r;
  logic [SETTLE_W-1:0] settle_r;
  logic [7:0]          restarts_r;
  logic                lock_r;
  logic                freeze_r;
  logic                restart_r;
  logic                eq_en_r;
  logic                invert_r;
  logic                color_r;
  logic                pol_out_r;
  logic                chroma_out_r;
  logic                signal_r;

  logic                access;
  logic                commit;
  logic                wr_commit;
  logic                hit_ctrl;
  logic                hit_status;
  logic                hit_settle;
  logic                mapped;
  logic                sw_restart;
  logic                pin_restart;
  logic                restart;
  logic                pol_mismatch;
  logic                settled;
  logic                settle_clear;
  logic                disturbed;

  // ----------------------------------------------------------------
  // APB request and address decode
  // ----------------------------------------------------------------
  assign req.sel   = psel;
  assign req.en    = penable;
  assign req.wr    = pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;

  // Access phase, and the edge where it completes
  assign access     = req.sel && req.en;
  assign commit     = access && pready_r;
  assign wr_commit  = commit && req.wr;

  // Register hits
  assign hit_ctrl   = (req.addr == veqlc_pkg::OFF_CTRL);
  assign hit_status = (req.addr == veqlc_pkg::OFF_STATUS);
  assign hit_settle = (req.addr == veqlc_pkg::OFF_SETTLE);
  assign mapped     = hit_ctrl || hit_status || hit_settle;

  // Software restart strobe, one cycle at the write edge
  assign sw_restart = wr_commit && hit_ctrl && req.wdata[veqlc_pkg::CTRL_RESTART_BIT];

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  assign status.restarts = restarts_r;
  assign status.state    = state_r;
  assign status.eq_en    = eq_en_r;
  assign status.signal   = signal_r;
  assign status.color    = color_r;
  assign status.invert   = invert_r;
  assign status.freeze   = freeze_r;
  assign status.lock     = lock_r;

  // Read data mux, unused bits read zero
  assign prdata_nxt = hit_status ? {8'h00, status.restarts, 5'h00, status.state,
                                    2'b00, status.eq_en, status.signal, status.color,
                                    status.invert, status.freeze, status.lock} :
                      hit_settle ? {{(32-SETTLE_W){1'b0}}, settle_r} :
                                   32'h0000_0000;

  // ----------------------------------------------------------------
  // APB response: one wait state, answer from flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r  <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      prdata_r  <= (access && !pready_r && !req.wr) ? prdata_nxt : 32'h0000_0000;
    end
  end

  // Settle threshold register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= SETTLE_W'(veqlc_pkg::SETTLE_LINES_RST);
    end else if (clk_en && wr_commit && hit_settle) begin
      settle_r <= req.wdata[SETTLE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Polarity and chroma pins
  // ----------------------------------------------------------------
  // Pin disagrees with our own drive: someone outside overdrives it
  assign pol_mismatch = (polarity_pin_in != pol_out_r);

  // Forced opposite level, held long enough, then released
  veqlc_toggle_qual #(
    .W       (veqlc_pkg::TOGGLE_CNT_W),
    .MIN_CYC (TOGGLE_MIN_CYC)
  ) veqlc_toggle_qual_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .mismatch (pol_mismatch),
    .fire     (pin_restart)                                    // RQ2
  );

  assign restart = pin_restart || sw_restart;

  // Drive detector results; the pin level, forced or not, steers the path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_out_r    <= 1'b0;
      chroma_out_r <= 1'b0;
      invert_r     <= 1'b0;
      color_r      <= 1'b0;
    end else if (clk_en) begin
      pol_out_r    <= polarity_detect;                         // RQ8
      chroma_out_r <= burst_detect;                            // RQ10
      invert_r     <= polarity_pin_in;                         // RQ9
      color_r      <= chroma_pin_in;                           // RQ11
    end
  end

  // ----------------------------------------------------------------
  // Settle detection
  // ----------------------------------------------------------------
  // No adaptation and no settling while disabled or without signal
  assign settle_clear = restart || !eq_en_r || !signal_present || (state_r != veqlc_pkg::VEQLC_ACQ);
  assign disturbed    = eq_settings_changed || !signal_present;

  veqlc_settle_cnt #(
    .W (SETTLE_W)
  ) veqlc_settle_cnt_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .clear   (settle_clear),
    .line    (line_strobe),
    .change  (eq_settings_changed),
    .thresh  (settle_r),
    .done    (settled)                                         // RQ5
  );

  // ----------------------------------------------------------------
  // Lock state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      veqlc_pkg::VEQLC_ACQ: begin
        if (!restart && !settle_clear && settled) begin
          state_nxt = veqlc_pkg::VEQLC_LOCK;                   // RQ5
        end
      end
      veqlc_pkg::VEQLC_LOCK: begin
        if (restart) begin
          state_nxt = veqlc_pkg::VEQLC_ACQ;                    // RQ14
        end else if (hold_select) begin
          state_nxt = veqlc_pkg::VEQLC_HOLD;                   // RQ4
        end else if (disturbed) begin
          state_nxt = veqlc_pkg::VEQLC_ACQ;                    // RQ6
        end
      end
      veqlc_pkg::VEQLC_HOLD: begin
        if (restart) begin
          state_nxt = veqlc_pkg::VEQLC_ACQ;                    // RQ1
        end else if (!hold_select) begin
          state_nxt = veqlc_pkg::VEQLC_LOCK;                   // RQ7
        end
      end
      default: begin
        state_nxt = veqlc_pkg::VEQLC_ACQ;
      end
    endcase
  end

  // State, starts acquiring on its own after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= veqlc_pkg::VEQLC_ACQ;                         // RQ12
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Lock, freeze, restart and enable outputs
  // ----------------------------------------------------------------
  // Lock stays high in hold whatever the signal does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r    <= 1'b0;
      freeze_r  <= 1'b0;
      restart_r <= 1'b0;
    end else if (clk_en) begin
      lock_r    <= (state_nxt != veqlc_pkg::VEQLC_ACQ);        // RQ3 RQ14
      freeze_r  <= (state_nxt == veqlc_pkg::VEQLC_HOLD);       // RQ1
      restart_r <= restart;                                    // RQ2
    end
  end

  // Equalization enable, one clk_en cycle behind the disable control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_en_r  <= 1'b1;
      signal_r <= 1'b0;
    end else if (clk_en) begin
      eq_en_r  <= !equalization_off;                           // RQ13
      signal_r <= signal_present;
    end
  end

  // Restart counter, wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restarts_r <= 8'h00;
    end else if (clk_en && restart) begin
      restarts_r <= restarts_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Port assignments
  // ----------------------------------------------------------------
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign lock_indicator    = lock_r;
  assign eq_freeze         = freeze_r;
  assign eq_restart        = restart_r;
  assign eq_enable         = eq_en_r;
  assign path_invert       = invert_r;
  assign path_color        = color_r;
  assign polarity_pin_out  = pol_out_r;
  assign polarity_pin_oe_n = 1'b0;
  assign chroma_pin_out    = chroma_out_r;
  assign chroma_pin_oe_n   = 1'b0;

endmodule : veqlc_top

//--- dv/veqlc_src_model.sv
// Far-side model: settled video source and equalizer engine feeding the block
`timescale 1ns/1ps
module veqlc_src_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sig_on,
  input  wire logic swapped,
  input  wire logic color,
  input  wire logic disturb,
  output logic      line_strobe,
  output logic      eq_settings_changed,
  output logic      signal_present,
  output logic      polarity_detect,
  output logic      burst_detect
);
  logic [1:0] ph_r;

  // One video line every four clocks while a signal is present
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_r <= 2'h0;
    else ph_r <= ph_r + 2'h1;
  end

  // Disturbance moves the settings once per line, even when frozen
  assign line_strobe         = sig_on && (ph_r == 2'h3);
  assign eq_settings_changed = line_strobe && disturb;
  assign signal_present      = sig_on;
  assign polarity_detect     = swapped;
  assign burst_detect        = color;
endmodule : veqlc_src_model

//--- dv/veqlc_top_sva.sv
// Checker of lock, restart and pin behaviour at the control block ports
`timescale 1ns/1ps
module veqlc_top_sva #(
  parameter int unsigned TOGGLE_MIN_CYC = 40000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_strobe,
  input wire logic        eq_settings_changed,
  input wire logic        signal_present,
  input wire logic        polarity_detect,
  input wire logic        burst_detect,
  input wire logic        eq_freeze,
  input wire logic        eq_restart,
  input wire logic        eq_enable,
  input wire logic        path_invert,
  input wire logic        path_color,
  input wire logic        hold_select,
  input wire logic        equalization_off,
  input wire logic        lock_indicator,
  input wire logic        polarity_pin_in,
  input wire logic        polarity_pin_out,
  input wire logic        polarity_pin_oe_n,
  input wire logic        chroma_pin_in,
  input wire logic        chroma_pin_out,
  input wire logic        chroma_pin_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic        up_r;
  logic [7:0]  thr_r;
  logic [8:0]  lines_r;
  logic [17:0] mm_r;
  wire         set_wr   = psel && penable && pready && pwrite && !pslverr && (paddr == veqlc_pkg::OFF_SETTLE);
  wire         line_clr = eq_settings_changed || !signal_present || !eq_enable;
  wire         pin_diff = polarity_pin_in != polarity_pin_out;

  // Threshold copy, settled line count, length of pin mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r    <= 1'b0;
      thr_r   <= veqlc_pkg::SETTLE_LINES_RST;
      lines_r <= 9'h000;
      mm_r    <= 18'h00000;
    end else if (clk_en) begin
      up_r <= 1'b1;
      if (set_wr) thr_r <= pwdata[7:0];
      if (line_clr) lines_r <= 9'h000;
      else if (eq_restart) lines_r <= {8'h00, line_strobe};
      else if (line_strobe && !lines_r[8]) lines_r <= lines_r + 9'h001;
      if (!pin_diff) mm_r <= 18'h00000;
      else if (!mm_r[17]) mm_r <= mm_r + 18'h00001;
    end
  end

  sequence s_access;
    !pready ##1 pready;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_freeze_held: assert property (eq_freeze && hold_select |=> (eq_freeze && lock_indicator) || eq_restart)
    else $error("frozen lock left without restart");
  a_pol_restart: assert property (mm_r >= TOGGLE_MIN_CYC && !pin_diff && clk_en |=> eq_restart)
    else $error("long polarity pulse gave no restart");
  a_restart_drop: assert property (eq_restart |-> !lock_indicator && !eq_freeze)
    else $error("lock kept over a restart");
  a_lock_lines: assert property ($rose(lock_indicator) |-> lines_r >= {1'b0, thr_r})
    else $error("lock before the settled line count");
  a_cont_unlock: assert property (lock_indicator && !eq_freeze && !hold_select && eq_settings_changed && clk_en
    |=> !lock_indicator)
    else $error("continuous lock kept after a change");
  a_cont_nofrz: assert property (!hold_select && clk_en |=> !eq_freeze)
    else $error("freeze with hold select low");
  a_pol_drive: assert property (up_r && clk_en |=> polarity_pin_out == $past(polarity_detect) && !polarity_pin_oe_n)
    else $error("polarity pin not driven from detector");
  a_inv_follow: assert property (up_r && clk_en |=> path_invert == $past(polarity_pin_in))
    else $error("path inversion not from pin level");
  a_chroma_drive: assert property (up_r && clk_en |=> chroma_pin_out == $past(burst_detect) && !chroma_pin_oe_n)
    else $error("chroma pin not driven from burst detector");
  a_color_follow: assert property (up_r && clk_en |=> path_color == $past(chroma_pin_in))
    else $error("color path not from pin level");
  a_eq_switch: assert property (up_r && clk_en |=> eq_enable == !$past(equalization_off))
    else $error("equalizer enable late");
  a_apb_wait: assert property (psel && !penable && clk_en |=> s_access)
    else $error("access not ended after one wait state");
endmodule : veqlc_top_sva

//--- dv/veqlc_top_tb.sv
// Self-checking bench for the video equalizer lock control
`timescale 1ns/1ps
module veqlc_top_tb;
  localparam int unsigned TMIN = 20;
  logic        pclk, pready, pslverr, line_strobe, eq_settings_changed, signal_present;
  logic        polarity_detect, burst_detect, eq_freeze, eq_restart, eq_enable, path_invert;
  logic        path_color, hold_select, lock_indicator, polarity_pin_in, polarity_pin_out;
  logic        polarity_pin_oe_n, chroma_pin_in, chroma_pin_out, chroma_pin_oe_n;
  logic        presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        equalization_off = 1'b0, sig_on = 1'b1, swapped = 1'b0, color = 1'b0, disturb = 1'b0;
  logic        tie_hold = 1'b0, pf_en = 1'b0, pf_v = 1'b0, cf_en = 1'b0, cf_v = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  int          num_errors = 0;
  int          n_compared = 0;

  // Board wiring: lock fed back to hold select, external forces win
  assign hold_select     = tie_hold ? lock_indicator : 1'b0;
  assign polarity_pin_in = pf_en ? pf_v : (polarity_pin_out ^ polarity_pin_oe_n);
  assign chroma_pin_in   = cf_en ? cf_v : (chroma_pin_out ^ chroma_pin_oe_n);

  veqlc_top #(.TOGGLE_MIN_CYC(TMIN)) veqlc_top_inst (.*);

  veqlc_src_model veqlc_src_model_inst (
    .pclk(pclk), .presetn(presetn), .sig_on(sig_on), .swapped(swapped), .color(color), .disturb(disturb),
    .line_strobe(line_strobe), .eq_settings_changed(eq_settings_changed), .signal_present(signal_present),
    .polarity_detect(polarity_detect), .burst_detect(burst_detect));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge pclk);
  endtask : step

  // One APB transfer, answer taken at the rising edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Wait for the lock level, counting video lines on the way
  task automatic wait_lock(input logic v, output int lines);
    int n;
    lines = 0;
    for (n = 0; n < 3000 && lock_indicator !== v; n++) begin
      if (line_strobe === 1'b1) lines++;
      @(negedge pclk);
    end
    if (lock_indicator !== v) begin
      num_errors++;
      complete_run();
    end
  endtask : wait_lock

  task automatic pol_force(input int n);
    @(posedge pclk);
    pf_v  <= ~swapped;
    pf_en <= 1'b1;
    step(n);
  endtask : pol_force

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    int          l;
    logic [31:0] rd;
    logic        er;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_lock(1'b1, l);
    chk(l, 32'h64);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk(rd, 32'h64);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h04, 32'hffffffff, rd, er);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd, 32'h00000231);
    @(posedge pclk);
    disturb <= 1'b1;
    wait_lock(1'b0, l);
    @(posedge pclk);
    disturb <= 1'b0;
    apb(1'b1, 8'h08, 32'h5, rd, er);
    wait_lock(1'b1, l);
    apb(1'b1, 8'h00, 32'h1, rd, er);
    chk(lock_indicator, 1'b0);
    wait_lock(1'b1, l);
    chk(l, 32'h5);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd, 32'h00010231);
    @(posedge pclk);
    tie_hold <= 1'b1;
    step(4);
    chk(eq_freeze, 1'b1);
    @(posedge pclk);
    sig_on <= 1'b0;
    step(40);
    chk(lock_indicator, 1'b1);
    @(posedge pclk);
    sig_on  <= 1'b1;
    disturb <= 1'b1;
    step(40);
    chk({lock_indicator, eq_freeze}, 2'b11);
    @(posedge pclk);
    disturb <= 1'b0;
    pol_force(TMIN / 2);
    @(posedge pclk);
    pf_en <= 1'b0;
    step(5);
    chk(lock_indicator, 1'b1);
    pol_force(TMIN + 10);
    @(posedge pclk);
    pf_en <= 1'b0;
    step(2);
    chk({lock_indicator, eq_freeze}, 2'b00);
    wait_lock(1'b1, l);
    chk(l, 32'h5);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd, 32'h00020433);
    @(posedge pclk);
    swapped <= 1'b1;
    step(3);
    chk({polarity_pin_out, path_invert}, 2'b11);
    pol_force(4);
    chk(path_invert, 1'b0);
    @(posedge pclk);
    pf_en   <= 1'b0;
    swapped <= 1'b0;
    color   <= 1'b1;
    step(3);
    chk({chroma_pin_out, path_color}, 2'b11);
    @(posedge pclk);
    cf_en <= 1'b1;
    step(3);
    chk(path_color, 1'b0);
    @(posedge pclk);
    cf_en            <= 1'b0;
    clk_en           <= 1'b0;
    equalization_off <= 1'b1;
    step(20);
    chk(eq_enable, 1'b1);
    @(posedge pclk);
    clk_en <= 1'b1;
    step(20);
    chk(eq_enable, 1'b0);
    @(posedge pclk);
    equalization_off <= 1'b0;
    step(20);
    chk(eq_enable, 1'b1);
    @(posedge pclk);
    tie_hold <= 1'b0;
    step(3);
    chk(eq_freeze, 1'b0);
    complete_run();
  end
endmodule : veqlc_top_tb

bind veqlc_top veqlc_top_sva #(.TOGGLE_MIN_CYC(TOGGLE_MIN_CYC)) veqlc_top_sva_inst (.*);
